/* sba_pkg.sv */
// Purpose: Shared constants for the sensor buffer and accumulator register bank.
// Assumes: Byte-wide register port with 8-bit offsets.
// Notes: Offsets, field layouts, reset values and decode codes for sba_regs live here; checks and bench repeat them as literals.
package sba_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_BUFFER_FILL_STATUS = 8'h01;
  localparam logic [7:0] OFF_ACCUMULATION_PROGRESS = 8'h02;
  localparam logic [7:0] OFF_CHAN0_SUM_LOW = 8'h08;
  localparam logic [7:0] OFF_CHAN0_SUM_HIGH = 8'h09;
  localparam logic [7:0] OFF_CHAN1_SUM_LOW = 8'h0a;
  localparam logic [7:0] OFF_CHAN1_SUM_HIGH = 8'h0b;
  localparam logic [7:0] OFF_SEQUENCE_LAUNCH = 8'h1e;
  localparam logic [7:0] OFF_OUTPUT_WORD_LAYOUT_CFG = 8'h28;
  localparam logic [7:0] OFF_BUFFER_CAPTURE_MODE_CFG = 8'h2c;
  localparam logic [7:0] OFF_SUMMING_ENABLE = 8'h30;
  localparam logic [7:0] OFF_PER_CHANNEL_ALERT_ENABLE = 8'h34;
  localparam logic [7:0] OFF_WINDOW_COMPARE_ENABLE_REG = 8'h37;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths and positions
  localparam int CAPTURE_MODE_W = 3;
  localparam int LAYOUT_W = 2;
  localparam int FILL_COUNT_W = 5;
  localparam int SUMMING_CODE_W = 4;
  localparam int ACC_DONE_W = 4;
  localparam int RESULT_W = 12;
  localparam int WORD_W = 16;
  localparam int CHAN_ID_W = 3;
  localparam int SUM_W = 16;
  localparam int ALERT_CHAN0_BIT = 0;
  localparam int ALERT_CHAN1_BIT = 1;
  localparam int LAUNCH_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] CAPTURE_MODE_RESET = 3'h1;
  localparam logic [1:0] LAYOUT_RESET = 2'h0;
  localparam logic [3:0] SUMMING_CODE_RESET = 4'h0;
  localparam logic [1:0] ALERT_ENABLE_RESET = 2'h0;
  localparam logic WINDOW_COMPARE_RESET = 1'b0;
  localparam logic [4:0] FILL_COUNT_RESET = 5'h00;
  localparam logic [3:0] ACC_DONE_RESET = 4'h0;
  localparam logic [15:0] SUM_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Decode codes and limits
  localparam logic [2:0] MODE_STOP_BURST = 3'h0;
  localparam logic [2:0] MODE_START_BURST = 3'h1;
  localparam logic [2:0] MODE_PRE_ALERT = 3'h4;
  localparam logic [2:0] MODE_POST_ALERT = 3'h6;
  localparam logic [1:0] LAYOUT_PLAIN = 2'h0;
  localparam logic [1:0] LAYOUT_WITH_ID = 2'h1;
  localparam logic [1:0] LAYOUT_ID_VALID = 2'h2;
  localparam logic [1:0] LAYOUT_PLAIN_ALT = 2'h3;
  localparam logic [3:0] SUMMING_ON = 4'hf;
  localparam logic [4:0] FILL_COUNT_MAX = 5'h10;
  localparam logic [2:0] CHAN_ID_ZERO = 3'h0;
  localparam logic [2:0] CHAN_ID_ONE = 3'h1;

endpackage

/* sba_word_fmt.sv */
// Purpose: Packs a 12-bit conversion result into the 16-bit buffered word.
// Assumes: Layout code comes straight from the layout register.
// Notes: Purely combinational; the caller registers the word.
`timescale 1ns/1ps
`default_nettype none
module sba_word_fmt (
  input wire logic [1:0] layout,
  input wire logic [11:0] result,
  input wire logic chan_one,
  input wire logic sample_valid,
  output logic [15:0] word
);

  logic [2:0] chan_id;

  ////////////////////////////////////////////////////////////////////////////
  // Channel identifier, zero or one
  // channel id code
  assign chan_id = chan_one ? sba_pkg::CHAN_ID_ONE : sba_pkg::CHAN_ID_ZERO;

  // Word layout select; the unused codes fall back to the zero-padded form
  always_comb begin
    unique case (layout)
      sba_pkg::LAYOUT_WITH_ID: word = {result, chan_id, 1'b0};
      sba_pkg::LAYOUT_ID_VALID: word = {result, chan_id, sample_valid};
      sba_pkg::LAYOUT_PLAIN, sba_pkg::LAYOUT_PLAIN_ALT: word = {result, 4'h0};
    endcase
  end

endmodule
`default_nettype wire

/* sba_regs.sv */
// Purpose: Control and status register bank of a two-channel sensor monitor.
// Assumes: The serial controller presents a byte register port on mclk; the
//   converter reports each finished conversion with a one-cycle pulse.
// Notes: Reads return data one cycle after the read strobe, with no side effect.
//   Control fields survive a launch; only status and sums restart from zero.
//   A conversion that meets a clear in the same cycle is dropped.
//
// Operation
// - Capture mode resets to start-burst; 000 stop, 001 start, 100 pre, 110 post.
// - Buffered word is 16 bits, shaped by a 2-bit layout resetting to 00.
// - Layout 00 or 11 gives the 12-bit result then four zeros.
// - Layout 01 appends a 3-bit channel id, 000 channel zero, 001 one.
// - Layout 10 gives result, channel id, then a sample-valid bit.
// - Read-only 5-bit count of filled buffer entries, 0 to 16.
// - Fill count, sums and accumulation count clear on resets or launch.
// - Accumulator runs only with enable code 1111; 0000 default keeps it off.
// - Channel zero sum reads as low byte 08h, high byte 09h.
// - Channel one sum reads as low byte 0Ah, high byte 0Bh.
// - Read-only 4-bit count of accumulations up to last finished conversion.
// - Window comparator enable at 37h, zero off by default, one on.
// - Per-channel alert enable sits at 34h, each channel separate.
// - Reserved bit positions always read as zero.
// - Alert enable bit 1 is channel one, bit 0 channel zero.
`timescale 1ns/1ps
`default_nettype none
module sba_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic general_call_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  input wire logic conv_chan_one,
  input wire logic conv_sample_valid,
  output logic [15:0] buffer_word,
  output logic buffer_word_valid,
  output logic [2:0] buffer_capture_mode,
  output logic capture_active,
  output logic summing_active,
  output logic window_compare_enable,
  output logic alert_enable_chan0,
  output logic alert_enable_chan1,
  output logic sequence_launch
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // True on a write strobe aimed at one offset
  // Shared by every writable offset and by the launch strobe
  function automatic logic wr_hit(input logic [7:0] addr, input logic wr,
                                  input logic [7:0] off);
    return wr && (addr == off);
  endfunction

  // Capture runs for any mode except stop-burst; the reserved codes also land
  // on the off side, so a stray reserved write parks the buffer rather than
  // starting a capture nobody asked for
  function automatic logic mode_captures(input logic [2:0] mode);
    logic on;
    on = 1'b0;
    unique case (mode)
      sba_pkg::MODE_START_BURST, sba_pkg::MODE_PRE_ALERT,
      sba_pkg::MODE_POST_ALERT: on = 1'b1;
      default: on = 1'b0;
    endcase
    return on;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0] capture_mode_reg, capture_mode_next;
  logic [1:0] layout_reg, layout_next;
  logic [3:0] summing_code_reg, summing_code_next;
  logic [1:0] alert_enable_reg, alert_enable_next;
  logic window_compare_reg, window_compare_next;
  logic [4:0] fill_count_reg, fill_count_next;
  logic [3:0] acc_done_reg, acc_done_next;
  logic [15:0] sum0_reg, sum0_next;
  logic [15:0] sum1_reg, sum1_next;
  logic [15:0] word_reg, word_next;
  logic word_valid_reg, word_valid_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [15:0] packed_word;
  logic launch_hit;
  logic status_clear;
  logic capturing;
  logic summing;
  logic [15:0] addend;

  ////////////////////////////////////////////////////////////////////////////
  // Word packing; done on the raw result so the word is ready for the
  // capture edge with no extra stage
  // 16-bit layout shaping
  sba_word_fmt u_fmt (
    .layout(layout_reg),
    .result(conv_result),
    .chan_one(conv_chan_one),
    .sample_valid(conv_sample_valid),
    .word(packed_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Writable fields; reserved bits are simply never stored, so they read back
  // as zero without any masking in the read mux.
  // Reserved capture and summing codes are stored as written and read back
  // unchanged; keeping them out is left to the host
  always_comb begin
    capture_mode_next = capture_mode_reg;
    layout_next = layout_reg;
    summing_code_next = summing_code_reg;
    alert_enable_next = alert_enable_reg;
    window_compare_next = window_compare_reg;
    if (wr_hit(reg_addr, reg_wr, sba_pkg::OFF_BUFFER_CAPTURE_MODE_CFG)) begin
      capture_mode_next = reg_wdata[sba_pkg::CAPTURE_MODE_W-1:0];
    end
    if (wr_hit(reg_addr, reg_wr, sba_pkg::OFF_OUTPUT_WORD_LAYOUT_CFG)) begin
      layout_next = reg_wdata[sba_pkg::LAYOUT_W-1:0];
    end
    if (wr_hit(reg_addr, reg_wr, sba_pkg::OFF_SUMMING_ENABLE)) begin
      summing_code_next = reg_wdata[sba_pkg::SUMMING_CODE_W-1:0];
    end
    if (wr_hit(reg_addr, reg_wr, sba_pkg::OFF_PER_CHANNEL_ALERT_ENABLE)) begin
      alert_enable_next = {reg_wdata[sba_pkg::ALERT_CHAN1_BIT],
                           reg_wdata[sba_pkg::ALERT_CHAN0_BIT]};
    end
    if (wr_hit(reg_addr, reg_wr, sba_pkg::OFF_WINDOW_COMPARE_ENABLE_REG)) begin
      window_compare_next = reg_wdata[0];
    end
  end

  // Control state; only device reset restores it, launch does not
  // A launch must not undo the set-up the host made just before it
  always_ff @(posedge mclk) begin
    if (rst) begin
      capture_mode_reg <= sba_pkg::CAPTURE_MODE_RESET;
      layout_reg <= sba_pkg::LAYOUT_RESET;
      summing_code_reg <= sba_pkg::SUMMING_CODE_RESET;
      alert_enable_reg <= sba_pkg::ALERT_ENABLE_RESET;
      window_compare_reg <= sba_pkg::WINDOW_COMPARE_RESET;
    end else begin
      capture_mode_reg <= capture_mode_next;
      layout_reg <= layout_next;
      summing_code_reg <= summing_code_next;
      alert_enable_reg <= alert_enable_next;
      window_compare_reg <= window_compare_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture, fill count and accumulator

  // Launch strobe; a write with bit 0 clear is a no-op
  assign launch_hit = wr_hit(reg_addr, reg_wr, sba_pkg::OFF_SEQUENCE_LAUNCH)
                      && reg_wdata[sba_pkg::LAUNCH_BIT];
  assign status_clear = general_call_reset || launch_hit;
  assign capturing = mode_captures(capture_mode_reg);
  assign summing = (summing_code_reg == sba_pkg::SUMMING_ON);
  assign addend = {4'h0, conv_result};

  // Counts and sums advance per finished conversion; clear takes priority
  // since a launch restarts capture from an empty buffer
  // A conversion with capture off still feeds the accumulator
  always_comb begin
    fill_count_next = fill_count_reg;
    acc_done_next = acc_done_reg;
    sum0_next = sum0_reg;
    sum1_next = sum1_reg;
    word_next = word_reg;
    word_valid_next = 1'b0;
    if (status_clear) begin
      fill_count_next = sba_pkg::FILL_COUNT_RESET;
      acc_done_next = sba_pkg::ACC_DONE_RESET;
      sum0_next = sba_pkg::SUM_RESET;
      sum1_next = sba_pkg::SUM_RESET;
    end else if (conv_done) begin
      if (capturing) begin
        word_next = packed_word;
        word_valid_next = 1'b1;
        if (fill_count_reg != sba_pkg::FILL_COUNT_MAX) begin
          fill_count_next = fill_count_reg + 5'h01;
        end
      end
      if (summing) begin
        acc_done_next = acc_done_reg + 4'h1;
        // Sum wraps at 16 bits; sixteen full-scale results still fit, longer
        // runs without a launch lose the carry, which the host must bear in
        // mind when it reads the two bytes
        if (conv_chan_one) begin
          sum1_next = sum1_reg + addend;
        end else begin
          sum0_next = sum0_reg + addend;
        end
      end
    end
  end

  // Status state; writes from the host never reach these registers
  // read-only writes ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      fill_count_reg <= sba_pkg::FILL_COUNT_RESET;
      acc_done_reg <= sba_pkg::ACC_DONE_RESET;
      sum0_reg <= sba_pkg::SUM_RESET;
      sum1_reg <= sba_pkg::SUM_RESET;
      word_reg <= 16'h0000;
      word_valid_reg <= 1'b0;
    end else begin
      fill_count_reg <= fill_count_next;
      acc_done_reg <= acc_done_next;
      sum0_reg <= sum0_next;
      sum1_reg <= sum1_next;
      word_reg <= word_next;
      word_valid_reg <= word_valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Registered read mux; no register changes on a read. A read and a write
  // in one cycle return the value from before the write, since the mux
  // looks at the registers and not at their next values.
  // Idle read data is forced to zero so a stray sample never shows stale data
  always_comb begin
    rdata_next = 8'h00;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        sba_pkg::OFF_BUFFER_FILL_STATUS: rdata_next = {3'h0, fill_count_reg};
        sba_pkg::OFF_ACCUMULATION_PROGRESS: rdata_next = {4'h0, acc_done_reg};
        sba_pkg::OFF_CHAN0_SUM_LOW: rdata_next = sum0_reg[7:0];
        sba_pkg::OFF_CHAN0_SUM_HIGH: rdata_next = sum0_reg[15:8];
        sba_pkg::OFF_CHAN1_SUM_LOW: rdata_next = sum1_reg[7:0];
        sba_pkg::OFF_CHAN1_SUM_HIGH: rdata_next = sum1_reg[15:8];
        sba_pkg::OFF_OUTPUT_WORD_LAYOUT_CFG: rdata_next = {6'h00, layout_reg};
        sba_pkg::OFF_BUFFER_CAPTURE_MODE_CFG: rdata_next = {5'h00, capture_mode_reg};
        sba_pkg::OFF_SUMMING_ENABLE: rdata_next = {4'h0, summing_code_reg};
        sba_pkg::OFF_PER_CHANNEL_ALERT_ENABLE: rdata_next = {6'h00, alert_enable_reg};
        sba_pkg::OFF_WINDOW_COMPARE_ENABLE_REG: rdata_next = {7'h00, window_compare_reg};
        // Write-only launch and unmapped offsets read zero
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Valid pulse follows the strobe by exactly one edge
  // side-effect free read
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign buffer_word = word_reg;
  assign buffer_word_valid = word_valid_reg;
  assign buffer_capture_mode = capture_mode_reg;
  // Decoded enables; one gate after a flop, so they settle well inside a cycle
  assign capture_active = capturing;
  assign summing_active = summing;
  assign window_compare_enable = window_compare_reg;
  assign alert_enable_chan0 = alert_enable_reg[sba_pkg::ALERT_CHAN0_BIT];
  assign alert_enable_chan1 = alert_enable_reg[sba_pkg::ALERT_CHAN1_BIT];
  // Launch pulse forwarded to the sequencer, same cycle as the write
  // Combinational so the sequencer starts on the write edge itself
  assign sequence_launch = launch_hit;

endmodule
`default_nettype wire

/* sba_regs_properties.sv */
// Purpose: Port checks for the sensor buffer register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound onto sba_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sba_regs_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic general_call_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  input wire logic [15:0] buffer_word,
  input wire logic buffer_word_valid,
  input wire logic [2:0] buffer_capture_mode,
  input wire logic capture_active,
  input wire logic summing_active,
  input wire logic window_compare_enable,
  input wire logic alert_enable_chan0,
  input wire logic alert_enable_chan1,
  input wire logic sequence_launch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Conversion taken: capture on and no clear in the same cycle
  sequence s_take;
    conv_done && capture_active && !general_call_reset && !sequence_launch;
  endsequence
  property p_word;
    s_take |=> buffer_word_valid && buffer_word[15:4] == $past(conv_result);
  endproperty
  a_word: assert property (p_word) else $error("word not captured");
  property p_no_stray;
    buffer_word_valid |-> $past(conv_done);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray word");
  property p_read;
    reg_rd |=> reg_rvalid;
  endproperty
  a_read: assert property (p_read) else $error("no read answer");
  property p_idle;
    !reg_rvalid |-> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_launch;
    sequence_launch == (reg_wr && reg_addr == 8'h1e && reg_wdata[0]);
  endproperty
  a_launch: assert property (p_launch) else $error("launch pulse wrong");
  property p_mode;
    reg_wr && reg_addr == 8'h2c |=> buffer_capture_mode == $past(reg_wdata[2:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("capture mode not written");
  property p_active;
    capture_active == (buffer_capture_mode inside {3'h1, 3'h4, 3'h6});
  endproperty
  a_active: assert property (p_active) else $error("capture decode wrong");
  property p_sum;
    reg_wr && reg_addr == 8'h30 |=> summing_active == ($past(reg_wdata[3:0]) == 4'hf);
  endproperty
  a_sum: assert property (p_sum) else $error("summing decode wrong");
  property p_window;
    reg_wr && reg_addr == 8'h37 |=> window_compare_enable == $past(reg_wdata[0]);
  endproperty
  a_window: assert property (p_window) else $error("window enable wrong");
  property p_alert;
    reg_wr && reg_addr == 8'h34 |=>
      {alert_enable_chan1, alert_enable_chan0} == $past(reg_wdata[1:0]);
  endproperty
  a_alert: assert property (p_alert) else $error("alert enables wrong");
endmodule
bind sba_regs sba_regs_properties i_props (
  .mclk(mclk), .rst(rst), .general_call_reset(general_call_reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_done(conv_done),
  .conv_result(conv_result), .buffer_word(buffer_word),
  .buffer_word_valid(buffer_word_valid), .buffer_capture_mode(buffer_capture_mode),
  .capture_active(capture_active), .summing_active(summing_active),
  .window_compare_enable(window_compare_enable),
  .alert_enable_chan0(alert_enable_chan0), .alert_enable_chan1(alert_enable_chan1),
  .sequence_launch(sequence_launch)
);
`default_nettype wire

/* sba_host.sv */
// Purpose: Host model driving the byte register port.
// Assumes: One strobe per access, changed just after mclk rises.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module sba_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  ////////////////////////////////////////////////////////////
  // Idle bus from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_wdata = 8'h00;
    reg_rd = 1'h0;
  end
  // Write; stale lines flipped so the design cannot lean on them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read; data taken while the valid pulse stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

/* sba_regs_tb.sv */
// Purpose: Self-checking bench for the sensor buffer register bank.
// Assumes: Host model on the register port, bench drives conversions.
// Notes: Fixed seed; all expectations come from the bench's own model.
`timescale 1ns/1ps
`default_nettype none
module sba_regs_tb;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic general_call_reset = 1'h0;
  logic conv_done = 1'h0;
  logic [11:0] conv_result = 12'h000;
  logic conv_chan_one = 1'h0;
  logic conv_sample_valid = 1'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, w;
  logic reg_wr, reg_rd, reg_rvalid, v;
  logic [15:0] buffer_word;
  logic buffer_word_valid, capture_active, summing_active, window_compare_enable;
  logic alert_enable_chan0, alert_enable_chan1, sequence_launch;
  logic [2:0] buffer_capture_mode;
  int num_errors = 0;
  int cmp_count = 0;
  logic [15:0] sums [2];
  logic [4:0] fill;
  logic [3:0] acc;
  logic [7:0] ro_offs [6] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b};
  logic [7:0] rw_offs [5] = '{8'h28, 8'h2c, 8'h30, 8'h34, 8'h37};
  logic [7:0] rw_mask [5] = '{8'h03, 8'h07, 8'h0f, 8'h03, 8'h01};
  logic [2:0] modes [4] = '{3'h1, 3'h4, 3'h6, 3'h0};
  logic [1:0] lay;
  int launches = 0;

  sba_regs i_dut (
    .mclk(mclk), .rst(rst), .general_call_reset(general_call_reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_done(conv_done),
    .conv_result(conv_result), .conv_chan_one(conv_chan_one),
    .conv_sample_valid(conv_sample_valid), .buffer_word(buffer_word),
    .buffer_word_valid(buffer_word_valid), .buffer_capture_mode(buffer_capture_mode),
    .capture_active(capture_active), .summing_active(summing_active),
    .window_compare_enable(window_compare_enable),
    .alert_enable_chan0(alert_enable_chan0), .alert_enable_chan1(alert_enable_chan1),
    .sequence_launch(sequence_launch)
  );
  sba_host h (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd)
  );

  // Launch pulses counted on the edge that takes them
  always @(posedge mclk) begin
    if (sequence_launch === 1'h1) launches <= launches + 1;
  end
  ////////////////////////////////////////////////////////////
  // 8 ns clock
  always #4 mclk = ~mclk;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Packed word as the layout code says
  function automatic logic [15:0] fmt(input logic [1:0] l, input logic [11:0] r,
      input logic c, input logic sv);
    case (l)
      2'h1: return {r, 2'h0, c, 1'h0};
      2'h2: return {r, 2'h0, c, sv};
      default: return {r, 4'h0};
    endcase
  endfunction

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    h.rd(a, d, v);
    chk("rvalid", 16'h0001, {15'h0, v}); // read answer
    chk("rdata", {8'h00, e}, {8'h00, d}); // read data
  endtask

  // Model counts back to their cleared state
  task automatic clr_model();
    fill = 5'h00;
    acc = 4'h0;
    sums = '{16'h0000, 16'h0000};
  endtask

  task automatic check_status();
    rchk(8'h01, {3'h0, fill}); // fill count
    rchk(8'h02, {4'h0, acc}); // accumulations
    for (int k = 0; k < 4; k++) begin
      rchk(8'h08 + k[7:0], sums[k / 2][8 * (k % 2) +: 8]); // sum bytes
    end
  endtask

  // One random conversion; the model follows only what the bench enabled
  task automatic conv(input logic [1:0] l, input logic cap, input logic s);
    logic [11:0] r;
    logic c;
    logic sv;
    r = 12'($urandom);
    c = 1'($urandom);
    sv = 1'($urandom);
    @(posedge mclk);
    conv_done <= 1'h1;
    conv_result <= r;
    conv_chan_one <= c;
    conv_sample_valid <= sv;
    @(posedge mclk);
    conv_done <= 1'h0;
    #1;
    chk("word_valid", {15'h0, cap}, {15'h0, buffer_word_valid}); // capture
    if (cap) begin
      chk("word", fmt(l, r, c, sv), buffer_word); // layout
      if (fill < 5'h10) fill = fill + 5'h01;
    end
    if (s) begin
      acc = acc + 4'h1;
      sums[c] = sums[c] + {4'h0, r};
    end
  endtask

  initial begin
    void'($urandom(32'h9925));
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    foreach (ro_offs[i]) rchk(ro_offs[i], 8'h00); // status reset
    foreach (rw_offs[i]) rchk(rw_offs[i], {7'h0, rw_offs[i] == 8'h2c}); // reset
    rchk(8'h1e, 8'h00); // launch reads zero
    rchk(8'h55, 8'h00); // unmapped
    // Random control values; coded fields kept to legal codes
    repeat (8) begin
      foreach (rw_offs[i]) begin
        w = 8'($urandom);
        if (i == 1) w[2:0] = modes[w[7:6]]; // legal modes
        if (i == 2) w[3:0] = {4{w[7]}}; // legal enables
        h.wr(rw_offs[i], w);
        rchk(rw_offs[i], w & rw_mask[i]); // reserved zero
        if (i == 1) chk("active", {15'h0, w[2:0] != 3'h0}, {15'h0, capture_active});
        if (i == 1) chk("mode", {13'h0, w[2:0]}, {13'h0, buffer_capture_mode});
        if (i == 2) chk("summing", {15'h0, w[7]}, {15'h0, summing_active});
        if (i == 3) chk("alert", {14'h0, w[1:0]}, {14'h0, alert_enable_chan1,
            alert_enable_chan0}); // per channel
        if (i == 4) chk("window", {15'h0, w[0]}, {15'h0, window_compare_enable});
      end
    end
    // Every layout captured, stop mode run with summing alone; 18 words
    // saturate fill and wrap accumulations
    for (int p = 0; p < 5; p++) begin
      lay = (p == 4) ? 2'h3 : 2'(p);
      h.wr(8'h28, {6'h00, lay});
      h.wr(8'h2c, {5'h0, modes[p % 4]});
      h.wr(8'h30, (p[0] || p[2]) ? 8'h0f : 8'h00);
      h.wr(8'h1e, 8'hfe); // bit 0 clear, no launch
      h.wr(8'h1e, 8'h01); // launch clears
      clr_model();
      repeat (18) conv(lay, modes[p % 4] != 3'h0, p[0] || p[2]);
      check_status(); // progress
      foreach (ro_offs[i]) h.wr(ro_offs[i], 8'hff); // ignored
      check_status(); // unchanged
    end
    // General call together with a conversion: the clear wins
    @(posedge mclk);
    general_call_reset <= 1'h1;
    conv_done <= 1'h1;
    @(posedge mclk);
    general_call_reset <= 1'h0;
    conv_done <= 1'h0;
    #1;
    chk("word_valid", 16'h0000, {15'h0, buffer_word_valid}); // clear wins
    clr_model();
    check_status(); // general call clears
    // Mid-run device reset restores control fields and clears status
    repeat (3) conv(lay, 1'h1, 1'h1);
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    clr_model();
    foreach (rw_offs[i]) rchk(rw_offs[i], {7'h0, rw_offs[i] == 8'h2c}); // reset
    check_status(); // device reset clears
    chk("launches", 16'h0005, launches[15:0]); // launch pulses
    end_sim();
  end

  // Watchdog far beyond the roughly 640 cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
